// ===== src/srl_params.svh
`ifndef SRL_PARAMS_SVH
`define SRL_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SRL_ADDR_W          4
`define SRL_ADDR_CTRL       4'h0
`define SRL_ADDR_SRC        4'h1
`define SRL_ADDR_STAT       4'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SRL_CTRL_RESET      8'h00
`define SRL_SRC_RESET       8'h00
`define SRL_ZERO_BYTE       8'h00

// ----------------------------------------------------------------
// latch_control_primary fields
// ----------------------------------------------------------------
`define SRL_CTRL_EN_BIT     7
`define SRL_CTRL_DIV_HI     6
`define SRL_CTRL_DIV_LO     4
`define SRL_CTRL_QEN_BIT    3
`define SRL_CTRL_NQEN_BIT   2
`define SRL_CTRL_PSET_BIT   1
`define SRL_CTRL_PRST_BIT   0

// ----------------------------------------------------------------
// latch_source_select fields
// ----------------------------------------------------------------
`define SRL_SRC_PIN_SET     7
`define SRL_SRC_CLK_SET     6
`define SRL_SRC_C2_SET      5
`define SRL_SRC_C1_SET      4
`define SRL_SRC_PIN_RST     3
`define SRL_SRC_CLK_RST     2
`define SRL_SRC_C2_RST      1
`define SRL_SRC_C1_RST      0

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define SRL_STAT_STATE_BIT  0
`define SRL_STAT_PIN_BIT    1
`define SRL_STAT_C1_BIT     2
`define SRL_STAT_C2_BIT     3

// ----------------------------------------------------------------
// divider: shortest period is 4 cycles, longest 512
// ----------------------------------------------------------------
`define SRL_DIV_SEL_W       3
`define SRL_DIV_MIN_LOG     2
`define SRL_DIV_CNT_W       9

`endif

// ===== src/srl_pkg.sv
package srl_pkg;

  // ----------------------------------------------------------------
  // latch state, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SRL_LATCH_RESET = 2'b01,
    SRL_LATCH_SET   = 2'b10
  } srl_state_t;

  typedef logic [7:0] srl_byte_t;
  typedef logic [2:0] srl_div_sel_t;

endpackage : srl_pkg

// ===== src/srl_div_if.sv
`timescale 1ns/100ps
`default_nettype none

interface srl_div_if;
  import srl_pkg::*;

  srl_div_sel_t divSel;
  logic         divPulse;

  modport owner
  (
    output divSel,
    input  divPulse
  );

  modport divider
  (
    input  divSel,
    output divPulse
  );

endinterface : srl_div_if

`default_nettype wire

// ===== src/srl_pulse_divider.sv
`timescale 1ns/100ps
`default_nettype none
`include "srl_params.svh"

module srl_pulse_divider
#(
  parameter int CNT_W = `SRL_DIV_CNT_W
)
(
  input  wire logic clock,     // system clock
  input  wire logic reset,     // async, active high
  srl_div_if.divider div       // select in, pulse out
);
  import srl_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  generate
    if (CNT_W < `SRL_DIV_CNT_W)
    begin : g_bad_width
      $error("divider counter too narrow for longest period");
    end
  endgenerate

  // ----------------------------------------------------------------
  // free-running counter and terminal-count pulse
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             pulse_q;
  logic             pulse_d;
  logic [CNT_W-1:0] termMask;

  // mask of period-1: 4<<sel minus one
  assign termMask = CNT_W'((CNT_W'(1) << (`SRL_DIV_MIN_LOG + div.divSel)) - CNT_W'(1));

  always_comb
  begin
    count_d = count_q + CNT_W'(1);
    // one clock wide, once per selected period
    pulse_d = ((count_q & termMask) == termMask);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      count_q <= '0;
      pulse_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      pulse_q <= pulse_d;
    end
  end

  assign div.divPulse = pulse_q;

endmodule : srl_pulse_divider

`default_nettype wire

// ===== src/srl_latch_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "srl_params.svh"

module srl_latch_unit
#(
  parameter int ADDR_W = `SRL_ADDR_W
)
(
  input  wire logic                  clock,             // system clock, 200 MHz
  input  wire logic                  reset,             // async, active high
  input  wire logic [ADDR_W-1:0]     regAddr,           // register address
  input  wire srl_pkg::srl_byte_t    regWriteData,      // write data
  input  wire logic                  regWrite,          // write strobe
  input  wire logic                  regRead,           // read strobe
  output var  srl_pkg::srl_byte_t    regReadData,       // read data, cycle after strobe
  input  wire logic                  latchInputPin,     // external set/reset pin
  input  wire logic [1:0]            comparatorOutput,  // [0] comp one, [1] comp two
  output logic                       trueOutputPin,     // true output level
  output logic                       trueOutputPinOe,   // true pin driver enable
  output logic                       invertedOutputPin, // inverted output level
  output logic                       invertedOutputPinOe // inverted pin driver enable
);
  import srl_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  generate
    if (ADDR_W < `SRL_ADDR_W)
    begin : g_bad_addr
      $error("address port too narrow for register map");
    end
    if ($bits(srl_div_sel_t) != `SRL_DIV_SEL_W)
    begin : g_bad_sel
      $error("divider select type does not match its field");
    end
  endgenerate

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam srl_byte_t CTRL_RST_VAL = `SRL_CTRL_RESET;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hitsReg
  (
    input logic [ADDR_W-1:0]     addr,
    input logic [`SRL_ADDR_W-1:0] offset
  );
    hitsReg = (addr == ADDR_W'(offset));
  endfunction : hitsReg

  logic wrCtrl;
  logic wrSrc;

  assign wrCtrl = regWrite && hitsReg(regAddr, `SRL_ADDR_CTRL);
  assign wrSrc  = regWrite && hitsReg(regAddr, `SRL_ADDR_SRC);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic         latchEnableBit_q;
  logic         latchEnableBit_d;
  srl_div_sel_t pulseDividerSelect_q;
  srl_div_sel_t pulseDividerSelect_d;
  logic         trueOutPinEnable_q;
  logic         trueOutPinEnable_d;
  logic         invertedOutPinEnable_q;
  logic         invertedOutPinEnable_d;
  logic         softSetPulse_q;
  logic         softSetPulse_d;
  logic         softResetPulse_q;
  logic         softResetPulse_d;
  srl_byte_t    sourceSelect_q;
  srl_byte_t    sourceSelect_d;

  always_comb
  begin
    latchEnableBit_d       = latchEnableBit_q;
    pulseDividerSelect_d   = pulseDividerSelect_q;
    trueOutPinEnable_d     = trueOutPinEnable_q;
    invertedOutPinEnable_d = invertedOutPinEnable_q;
    sourceSelect_d         = sourceSelect_q;
    // self-clearing: high for exactly one clock after the write
    softSetPulse_d         = 1'b0;
    softResetPulse_d       = 1'b0;
    if (wrCtrl)
    begin
      latchEnableBit_d       = regWriteData[`SRL_CTRL_EN_BIT];
      pulseDividerSelect_d   = regWriteData[`SRL_CTRL_DIV_HI:`SRL_CTRL_DIV_LO];
      trueOutPinEnable_d     = regWriteData[`SRL_CTRL_QEN_BIT];
      invertedOutPinEnable_d = regWriteData[`SRL_CTRL_NQEN_BIT];
      softSetPulse_d         = regWriteData[`SRL_CTRL_PSET_BIT];
      softResetPulse_d       = regWriteData[`SRL_CTRL_PRST_BIT];
    end
    if (wrSrc)
    begin
      sourceSelect_d = regWriteData;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      latchEnableBit_q       <= CTRL_RST_VAL[`SRL_CTRL_EN_BIT];
      pulseDividerSelect_q   <= CTRL_RST_VAL[`SRL_CTRL_DIV_HI:`SRL_CTRL_DIV_LO];
      trueOutPinEnable_q     <= CTRL_RST_VAL[`SRL_CTRL_QEN_BIT];
      invertedOutPinEnable_q <= CTRL_RST_VAL[`SRL_CTRL_NQEN_BIT];
      softSetPulse_q         <= CTRL_RST_VAL[`SRL_CTRL_PSET_BIT];
      softResetPulse_q       <= CTRL_RST_VAL[`SRL_CTRL_PRST_BIT];
      sourceSelect_q         <= `SRL_SRC_RESET;
    end
    else
    begin
      latchEnableBit_q       <= latchEnableBit_d;
      pulseDividerSelect_q   <= pulseDividerSelect_d;
      trueOutPinEnable_q     <= trueOutPinEnable_d;
      invertedOutPinEnable_q <= invertedOutPinEnable_d;
      softSetPulse_q         <= softSetPulse_d;
      softResetPulse_q       <= softResetPulse_d;
      sourceSelect_q         <= sourceSelect_d;
    end
  end

  // ----------------------------------------------------------------
  // pulse divider
  // ----------------------------------------------------------------
  srl_div_if divLink ();

  assign divLink.divSel = pulseDividerSelect_q;

  srl_pulse_divider
  #(
    .CNT_W (`SRL_DIV_CNT_W)
  )
  u_divider
  (
    .clock (clock),
    .reset (reset),
    .div   (divLink.divider)
  );

  // ----------------------------------------------------------------
  // set and reset source gating
  // ----------------------------------------------------------------
  // a source counts only while its select bit is set
  function automatic logic gated
  (
    input logic enable,
    input logic level
  );
    gated = enable && level;
  endfunction : gated

  logic pinSetTerm;
  logic clkSetTerm;
  logic compSetTerm;
  logic pinRstTerm;
  logic clkRstTerm;
  logic compRstTerm;
  logic latchSet;
  logic latchReset;

  always_comb
  begin
    pinSetTerm  = gated(sourceSelect_q[`SRL_SRC_PIN_SET], latchInputPin);
    clkSetTerm  = gated(sourceSelect_q[`SRL_SRC_CLK_SET], divLink.divPulse);
    compSetTerm = gated(sourceSelect_q[`SRL_SRC_C2_SET], comparatorOutput[1])
               || gated(sourceSelect_q[`SRL_SRC_C1_SET], comparatorOutput[0]);
    pinRstTerm  = gated(sourceSelect_q[`SRL_SRC_PIN_RST], latchInputPin);
    clkRstTerm  = gated(sourceSelect_q[`SRL_SRC_CLK_RST], divLink.divPulse);
    compRstTerm = gated(sourceSelect_q[`SRL_SRC_C2_RST], comparatorOutput[1])
               || gated(sourceSelect_q[`SRL_SRC_C1_RST], comparatorOutput[0]);
    // active-high inputs, any enabled source suffices
    latchSet    = softSetPulse_q || pinSetTerm || clkSetTerm || compSetTerm;
    latchReset  = softResetPulse_q || pinRstTerm || clkRstTerm || compRstTerm;
  end

  // ----------------------------------------------------------------
  // latch state
  // ----------------------------------------------------------------
  srl_state_t latchState_q;
  srl_state_t latchState_d;

  always_comb
  begin
    latchState_d = latchState_q;
    // disabled latch ignores its inputs and holds
    if (latchEnableBit_q)
    begin
      if (latchReset)
      begin
        latchState_d = SRL_LATCH_RESET;
      end
      else if (latchSet)
      begin
        latchState_d = SRL_LATCH_SET;
      end
    end
  end

  // no reset term: state survives, and is unknown after power-up
  always_ff @(posedge clock)
  begin
    latchState_q <= latchState_d;
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  logic latchQ;

  always_comb
  begin
    unique case (latchState_q)
      SRL_LATCH_SET:   latchQ = 1'b1;
      SRL_LATCH_RESET: latchQ = 1'b0;
      default:         latchQ = 1'b0;
    endcase
  end

  // driven only while enabled; enabling does not define the state, so the power-up state reaches a pin until the first set or reset
  assign trueOutputPinOe     = latchEnableBit_q && trueOutPinEnable_q;
  assign invertedOutputPinOe = latchEnableBit_q && invertedOutPinEnable_q;
  assign trueOutputPin       = trueOutputPinOe && latchQ;
  assign invertedOutputPin   = invertedOutputPinOe && !latchQ;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  srl_byte_t readData_q;
  srl_byte_t readData_d;
  srl_byte_t ctrlView;
  srl_byte_t statView;

  always_comb
  begin
    ctrlView = `SRL_ZERO_BYTE;
    ctrlView[`SRL_CTRL_EN_BIT]                     = latchEnableBit_q;
    ctrlView[`SRL_CTRL_DIV_HI:`SRL_CTRL_DIV_LO]    = pulseDividerSelect_q;
    ctrlView[`SRL_CTRL_QEN_BIT]                    = trueOutPinEnable_q;
    ctrlView[`SRL_CTRL_NQEN_BIT]                   = invertedOutPinEnable_q;
    // pulse bits stay zero on read
    ctrlView[`SRL_CTRL_PSET_BIT]                   = 1'b0;
    ctrlView[`SRL_CTRL_PRST_BIT]                   = 1'b0;
    statView = `SRL_ZERO_BYTE;
    statView[`SRL_STAT_STATE_BIT] = latchQ;
    statView[`SRL_STAT_PIN_BIT]   = latchInputPin;
    statView[`SRL_STAT_C1_BIT]    = comparatorOutput[0];
    statView[`SRL_STAT_C2_BIT]    = comparatorOutput[1];
    readData_d = `SRL_ZERO_BYTE;
    if (regRead)
    begin
      if (hitsReg(regAddr, `SRL_ADDR_CTRL))
      begin
        readData_d = ctrlView;
      end
      else if (hitsReg(regAddr, `SRL_ADDR_SRC))
      begin
        readData_d = sourceSelect_q;
      end
      else if (hitsReg(regAddr, `SRL_ADDR_STAT))
      begin
        readData_d = statView;
      end
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      readData_q <= `SRL_ZERO_BYTE;
    end
    else
    begin
      readData_q <= readData_d;
    end
  end

  assign regReadData = readData_q;

endmodule : srl_latch_unit

`default_nettype wire

// ===== test/srl_latch_unit_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "srl_params.svh"

module srl_latch_chk
#(
  parameter int ADDR_W = `SRL_ADDR_W
)
(
  input wire logic               clock,               // clk
  input wire logic               reset,               // rst
  input wire logic [ADDR_W-1:0]  regAddr,             // addr
  input wire srl_pkg::srl_byte_t regWriteData,        // wdata
  input wire logic               regWrite,            // wr
  input wire logic               regRead,             // rd
  input wire srl_pkg::srl_byte_t regReadData,         // rdata
  input wire logic               latchInputPin,       // pin
  input wire logic [1:0]         comparatorOutput,    // comps
  input wire logic               trueOutputPin,       // q
  input wire logic               trueOutputPinOe,     // q oe
  input wire logic               invertedOutputPin,   // nq
  input wire logic               invertedOutputPinOe  // nq oe
);
  import srl_pkg::*;

  srl_byte_t ctrlShadow_q;
  srl_byte_t srcShadow_q;

  // ----------------------------------------
  // register shadow
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ctrlShadow_q <= 8'h00;
      srcShadow_q  <= 8'h00;
    end
    else if (regWrite && regAddr == `SRL_ADDR_CTRL)
      ctrlShadow_q <= regWriteData;
    else if (regWrite && regAddr == `SRL_ADDR_SRC)
      srcShadow_q <= regWriteData;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_ctrlWr(logic [1:0] pulse);
    regWrite && regAddr == `SRL_ADDR_CTRL && regWriteData[7] && regWriteData[3]
      && regWriteData[1:0] == pulse && srcShadow_q == 8'h00;
  endsequence
  sequence s_quiet;
    !regWrite [*2];
  endsequence

  property p_trueOe;
    trueOutputPinOe == (ctrlShadow_q[7] && ctrlShadow_q[3]);
  endproperty
  property p_invOe;
    invertedOutputPinOe == (ctrlShadow_q[7] && ctrlShadow_q[2]);
  endproperty
  property p_off;
    !ctrlShadow_q[7] |-> !trueOutputPin && !invertedOutputPin;
  endproperty
  property p_both;
    trueOutputPinOe && invertedOutputPinOe |-> trueOutputPin != invertedOutputPin;
  endproperty
  property p_softSet;
    s_ctrlWr(2'b10) ##1 s_quiet |=> trueOutputPin;
  endproperty
  property p_softBoth;
    s_ctrlWr(2'b11) ##1 s_quiet |=> !trueOutputPin;
  endproperty
  property p_ctrlRead;
    regRead && regAddr == `SRL_ADDR_CTRL |=> regReadData[1:0] == 2'b00;
  endproperty
  property p_srcRead;
    regRead && regAddr == `SRL_ADDR_SRC |=> regReadData == srcShadow_q;
  endproperty
  property p_pinSet;
    (ctrlShadow_q[7] && ctrlShadow_q[3] && srcShadow_q == 8'h80 && latchInputPin) [*3] |-> trueOutputPin;
  endproperty
  property p_clkRst;
    (ctrlShadow_q[7] && ctrlShadow_q[6:4] == 3'h0 && srcShadow_q == 8'h04) [*8] |-> !trueOutputPin;
  endproperty

  a_trueOe:   assert property (p_trueOe)   else $error("true pin enable wrong");
  a_invOe:    assert property (p_invOe)    else $error("inverted pin enable wrong");
  a_off:      assert property (p_off)      else $error("pins active while off");
  a_both:     assert property (p_both)     else $error("pins not complementary");
  a_softSet:  assert property (p_softSet)  else $error("soft set had no effect");
  a_softBoth: assert property (p_softBoth) else $error("set beat reset");
  a_ctrlRead: assert property (p_ctrlRead) else $error("pulse bits read nonzero");
  a_srcRead:  assert property (p_srcRead)  else $error("source select readback");
  a_pinSet:   assert property (p_pinSet)   else $error("pin did not set latch");
  a_clkRst:   assert property (p_clkRst)   else $error("divider did not reset");
endmodule : srl_latch_chk

`default_nettype wire

// ===== test/tb_srl_latch_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "srl_params.svh"

module tb_srl_latch_unit;
  import srl_pkg::*;

  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] regAddr = 4'h0;
  srl_byte_t  regWriteData = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  srl_byte_t  regReadData;
  logic       latchInputPin = 1'b0;
  logic [1:0] comparatorOutput = 2'h0;
  logic       trueOutputPin;
  logic       trueOutputPinOe;
  logic       invertedOutputPin;
  logic       invertedOutputPinOe;
  int         mismatches = 0;
  int         comparisons = 0;

  always #2.5 clock = ~clock;

  srl_latch_unit dut_u
  (
    .clock(clock),
    .reset(reset),
    .regAddr(regAddr),
    .regWriteData(regWriteData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regReadData(regReadData),
    .latchInputPin(latchInputPin),
    .comparatorOutput(comparatorOutput),
    .trueOutputPin(trueOutputPin),
    .trueOutputPinOe(trueOutputPinOe),
    .invertedOutputPin(invertedOutputPin),
    .invertedOutputPinOe(invertedOutputPinOe)
  );

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic wr(input logic [3:0] a, input srl_byte_t d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input srl_byte_t e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    check({8'h00, regReadData}, {8'h00, e});
  endtask : rd

  task automatic outs(input logic [3:0] e);
    #1;
    check({12'h000, trueOutputPinOe, invertedOutputPinOe, trueOutputPin, invertedOutputPin}, {12'h000, e});
  endtask : outs

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic regCase();
    rd(`SRL_ADDR_CTRL, 8'h00);
    rd(`SRL_ADDR_SRC, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    wr(`SRL_ADDR_SRC, 8'ha5);
    rd(`SRL_ADDR_SRC, 8'ha5);
  endtask : regCase

  task automatic srcCase(input srl_byte_t src, input logic pin, input logic [1:0] cmp, input logic init,
                         input logic e);
    wr(`SRL_ADDR_SRC, 8'h00);
    latchInputPin <= pin;
    comparatorOutput <= cmp;
    wr(`SRL_ADDR_CTRL, init ? 8'h8e : 8'h8d);
    tick(3);
    outs({2'b11, init, !init});
    wr(`SRL_ADDR_SRC, src);
    tick(9);
    outs({2'b11, e, !e});
  endtask : srcCase

  task automatic softCase();
    wr(`SRL_ADDR_SRC, 8'h00);
    wr(`SRL_ADDR_CTRL, 8'h8e);
    tick(3);
    rd(`SRL_ADDR_STAT, 8'h03);
    wr(`SRL_ADDR_CTRL, 8'h8f);
    tick(3);
    outs(4'b1101);
    rd(`SRL_ADDR_CTRL, 8'h8c);
    rd(`SRL_ADDR_STAT, 8'h02);
    wr(`SRL_ADDR_CTRL, 8'h88);
    outs(4'b1000);
    wr(`SRL_ADDR_CTRL, 8'h84);
    outs(4'b0101);
    wr(`SRL_ADDR_CTRL, 8'h00);
    outs(4'b0000);
  endtask : softCase

  task automatic waitLow(output int n);
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end
    while (trueOutputPin !== 1'b0 && n < 600);
  endtask : waitLow

  task automatic divCase(input logic [2:0] sel);
    int n;
    wr(`SRL_ADDR_CTRL, {1'b1, sel, 4'h8});
    waitLow(n);
    waitLow(n);
    check(16'(n), 16'(4 << sel));
  endtask : divCase

  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    regCase();
    wr(`SRL_ADDR_CTRL, 8'h82);
    tick(3);
    srcCase(8'h80, 1'b1, 2'h0, 1'b0, 1'b1);
    srcCase(8'h40, 1'b0, 2'h0, 1'b0, 1'b1);
    srcCase(8'h20, 1'b0, 2'h2, 1'b0, 1'b1);
    srcCase(8'h10, 1'b0, 2'h1, 1'b0, 1'b1);
    srcCase(8'h30, 1'b0, 2'h1, 1'b0, 1'b1);
    srcCase(8'h08, 1'b1, 2'h0, 1'b1, 1'b0);
    srcCase(8'h04, 1'b0, 2'h0, 1'b1, 1'b0);
    srcCase(8'h02, 1'b0, 2'h2, 1'b1, 1'b0);
    srcCase(8'h01, 1'b0, 2'h1, 1'b1, 1'b0);
    srcCase(8'h00, 1'b1, 2'h3, 1'b0, 1'b0);
    srcCase(8'h00, 1'b1, 2'h3, 1'b1, 1'b1);
    srcCase(8'h88, 1'b1, 2'h0, 1'b1, 1'b0);
    softCase();
    wr(`SRL_ADDR_SRC, 8'h84);
    latchInputPin <= 1'b1;
    for (int s = 0; s < 8; s++)
      divCase(3'(s));
    close_out();
  end
endmodule : tb_srl_latch_unit

bind srl_latch_unit srl_latch_chk #(.ADDR_W(ADDR_W)) chk_u
(
  .clock(clock),
  .reset(reset),
  .regAddr(regAddr),
  .regWriteData(regWriteData),
  .regWrite(regWrite),
  .regRead(regRead),
  .regReadData(regReadData),
  .latchInputPin(latchInputPin),
  .comparatorOutput(comparatorOutput),
  .trueOutputPin(trueOutputPin),
  .trueOutputPinOe(trueOutputPinOe),
  .invertedOutputPin(invertedOutputPin),
  .invertedOutputPinOe(invertedOutputPinOe)
);

`default_nettype wire
